// ---- verif/modem_monitor.sv ----
// concurrent checks on the host serial connector between modem end and host end
`timescale 1ns/1ps
module modem_monitor #(
  parameter int BIT_CYC = 2083
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic host_serial_in,
  input wire logic host_serial_out,
  input wire logic clr_to_send_n,
  input wire logic req_to_send_n,
  input wire logic learn_dev_out,
  input wire logic learn_dev_oe,
  input wire logic learn_host_out,
  input wire logic learn_host_oe
);
  // ==========================================
  // frame trackers
  // counts from the first low sample; a cycle of drift per frame is harmless at mid-bit
  localparam int FR = 10 * BIT_CYC;
  int f_in;
  int f_out;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      f_in <= 0;
    end else if (f_in != 0) begin
      f_in <= (f_in == FR - 1) ? 0 : f_in + 1;
    end else if (!host_serial_in) begin
      f_in <= 1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      f_out <= 0;
    end else if (f_out != 0) begin
      f_out <= (f_out == FR - 1) ? 0 : f_out + 1;
    end else if (!host_serial_out) begin
      f_out <= 1;
    end
  end
  // ==========================================
  // assertions
  a_cts_after_rst:
    assert property ($rose(rst_b) |-> ##[0:3] !clr_to_send_n) else $error("cts not low");
  a_in_start_cts:
    assert property (f_in == 0 && !host_serial_in |-> !$past(clr_to_send_n, 3))
    else $error("host started while cts high");
  a_out_start_rts:
    assert property (f_out == 0 && !host_serial_out |-> !$past(req_to_send_n, 3))
    else $error("modem started while rts high");
  a_in_start_mid:
    assert property (f_in == BIT_CYC / 2 |-> !host_serial_in) else $error("bad start in");
  a_in_stop_mid:
    assert property (f_in == 19 * BIT_CYC / 2 |-> host_serial_in) else $error("bad stop in");
  a_out_start_mid:
    assert property (f_out == BIT_CYC / 2 |-> !host_serial_out) else $error("bad start out");
  a_out_stop_mid:
    assert property (f_out == 19 * BIT_CYC / 2 |-> host_serial_out) else $error("bad stop out");
  a_dev_open_drain:
    assert property (learn_dev_oe |-> !learn_dev_out) else $error("modem drives pin high");
  a_host_open_drain:
    assert property (learn_host_oe |-> !learn_host_out) else $error("host drives pin high");
  a_press_hold:
    assert property ($rose(learn_host_oe) |-> learn_host_oe [*8]) else $error("press too short");
endmodule : modem_monitor

// ---- verif/radio_modem_host_port_tb.sv ----
// self-checking bench: modem end and host end joined over the connector
`timescale 1ns/1ps
module radio_modem_host_port_tb;
  import modem_pkg::*;
  logic sys_clk, rst_b, host_rate_strap, radio_rate_strap, mode_strap, rate_sel;
  logic addressed_mode, elem_tick, radio_tx_valid, radio_tx_ready, radio_frame_sent;
  logic radio_ack, radio_no_ack, radio_retry, radio_rx_valid, radio_rx_ready;
  logic learn_start, learn_done, tx_valid, tx_ready, rx_valid, rx_enable;
  logic learn_press, indicator_lit;
  byte_t radio_tx_data, radio_rx_data, tx_data, rx_data;
  int mismatches = 0;
  int tests_run = 0;
  int n, m;
  modem_if link_if ();
  // short element and learn counts keep the run small
  modem_device #(.ELEM_CYC_HI(40), .ELEM_CYC_LO(80), .LEARN_WAIT_CYC(8000),
    .LEARN_FLASH_CYC(400), .FLASH_HALF_CYC(20)) modem_device_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link_if), .host_rate_strap(host_rate_strap),
    .radio_rate_strap(radio_rate_strap), .mode_strap(mode_strap),
    .addressed_mode(addressed_mode), .elem_tick(elem_tick), .radio_tx_data(radio_tx_data),
    .radio_tx_valid(radio_tx_valid), .radio_tx_ready(radio_tx_ready),
    .radio_frame_sent(radio_frame_sent), .radio_ack(radio_ack), .radio_no_ack(radio_no_ack),
    .radio_retry(radio_retry), .radio_rx_data(radio_rx_data), .radio_rx_valid(radio_rx_valid),
    .radio_rx_ready(radio_rx_ready), .learn_start(learn_start), .learn_done(learn_done));
  modem_host modem_host_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link_if), .rate_sel(rate_sel), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_enable(rx_enable), .learn_press(learn_press), .indicator_lit(indicator_lit));
  modem_monitor modem_monitor_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .host_serial_in(link_if.host_serial_in),
    .host_serial_out(link_if.host_serial_out), .clr_to_send_n(link_if.clr_to_send_n),
    .req_to_send_n(link_if.req_to_send_n), .learn_dev_out(link_if.learn_dev_out),
    .learn_dev_oe(link_if.learn_dev_oe), .learn_host_out(link_if.learn_host_out),
    .learn_host_oe(link_if.learn_host_oe));
  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic sig(input int k);
    case (k)
      0: return radio_tx_valid;
      1: return rx_valid;
      2: return radio_retry;
      3: return learn_start;
      4: return elem_tick;
      5: return tx_ready;
      default: return radio_rx_ready;
    endcase
  endfunction : sig
  // sampled at the edge itself, so a one-cycle pulse is never missed
  task automatic wt(input int k, input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (sig(k) !== 1'h1 && n < lim);
    if (sig(k) !== 1'h1) begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      test_done();
    end
  endtask : wt
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: radio_frame_sent <= 1'h1;
      1: radio_no_ack <= 1'h1;
      2: radio_ack <= 1'h1;
      3: learn_press <= 1'h1;
      default: learn_done <= 1'h1;
    endcase
    @(posedge sys_clk);
    {radio_frame_sent, radio_no_ack, radio_ack, learn_press, learn_done} <= 5'h0;
  endtask : pulse
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // ==========================================
  // stimulus
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    rst_b = 1'h0;
    {host_rate_strap, rate_sel, radio_rate_strap, mode_strap} = 4'h3;
    {radio_tx_ready, radio_frame_sent, radio_ack, radio_no_ack, radio_rx_valid} = 5'h0;
    {learn_done, tx_valid, rx_enable, learn_press} = 4'h0;
    {radio_rx_data, tx_data} = 16'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge sys_clk);
    chk(addressed_mode, 8'h1);
    chk(link_if.clr_to_send_n, 8'h0);
    mode_strap <= 1'h0;
    wt(4, 100);
    wt(4, 100);
    chk(8'(n), 8'h28);
    // second tick ends the first period wholly after the strap change; the third is checked
    radio_rate_strap <= 1'h0;
    wt(4, 100);
    wt(4, 100);
    wt(4, 100);
    chk(8'(n), 8'h50);
    chk(addressed_mode, 8'h1);
    // radio byte first: its delivery to the host lands just before the host byte's
    rx_enable <= 1'h1;
    radio_rx_data <= 8'h3c;
    radio_rx_valid <= 1'h1;
    wt(6, 50);
    radio_rx_valid <= 1'h0;
    tx_data <= 8'ha5;
    tx_valid <= 1'h1;
    wt(5, 50);
    tx_data <= 8'h5a;
    wt(1, 30000);
    chk(rx_data, 8'h3c);
    wt(0, 30000);
    chk(radio_tx_data, 8'ha5);
    radio_tx_ready <= 1'h1;
    @(posedge sys_clk);
    radio_tx_ready <= 1'h0;
    // second host byte waits, valid held, until the first frame ends
    wt(5, 2000);
    tx_valid <= 1'h0;
    pulse(0);
    for (m = 0; m < 5; m++) begin
      pulse(1);
      wt(2, 3);
    end
    pulse(1);
    wt(1, 30000);
    chk(rx_data, 8'h46);
    wt(0, 30000);
    chk(radio_tx_data, 8'h5a);
    radio_tx_ready <= 1'h1;
    @(posedge sys_clk);
    radio_tx_ready <= 1'h0;
    @(posedge sys_clk);
    chk(radio_tx_valid, 8'h0);
    pulse(0);
    pulse(2);
    wt(1, 30000);
    chk(rx_data, 8'h43);
    pulse(3);
    wt(3, 30);
    repeat (4100) @(posedge sys_clk);
    chk(indicator_lit, 8'h1);
    pulse(4);
    n = 0;
    repeat (400) begin
      @(posedge sys_clk);
      if (indicator_lit === 1'h1) n++;
    end
    chk(8'(n > 150 && n < 250), 8'h1);
    repeat (100) @(posedge sys_clk);
    chk(indicator_lit, 8'h0);
    // second power-up: broadcast mode strapped, 9600 baud on both ends
    rst_b <= 1'h0;
    {host_rate_strap, rate_sel} <= 2'h3;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge sys_clk);
    chk(addressed_mode, 8'h0);
    chk(link_if.clr_to_send_n, 8'h0);
    pulse(0);
    pulse(2);
    repeat (6) @(posedge sys_clk);
    chk(link_if.host_serial_out, 8'h1);
    radio_rx_data <= 8'hff;
    radio_rx_valid <= 1'h1;
    wt(6, 50);
    radio_rx_valid <= 1'h0;
    // all-ones byte: the only low time on the line is the start bit
    n = 0;
    while (link_if.host_serial_out === 1'h1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    m = 0;
    while (link_if.host_serial_out === 1'h0 && m < 5000) begin
      @(posedge sys_clk);
      m++;
    end
    chk(16'(m), 16'h1047);
    test_done();
  end
endmodule : radio_modem_host_port_tb

// ---- verilog/modem_defines.svh ----
// shared constants for the radio modem host port and its host end
`ifndef MODEM_DEFINES_SVH
`define MODEM_DEFINES_SVH
// ==========================================
// clocking and serial rates
`define CLK_HZ 40000000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define CYC_PER_MS (`CLK_HZ / 1000)
`define BAUD_HI 9600
`define BAUD_LO 19200
`define BIT_CYC_HI 13'((`CLK_HZ + `BAUD_HI / 2) / `BAUD_HI)
`define BIT_CYC_LO 13'((`CLK_HZ + `BAUD_LO / 2) / `BAUD_LO)
`define UART_STOP_BIT 4'h9
`define UART_IDLE_FRAME 10'h3ff
// ==========================================
// radio element time
`define ELEM_US_HI 400
`define ELEM_US_LO 800
// ==========================================
// addressed transfer reporting
`define RETRY_MAX 3'h5
`define CHAR_CONFIRM 8'h43
`define CHAR_FAIL 8'h46
// ==========================================
// buffering and pacing
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define CTS_MARGIN 5'h2
// ==========================================
// learn pin timing
`define LEARN_WAIT_MS 20000
`define LEARN_FLASH_MS 3000
`define FLASH_HALF_MS 50
`define PRESS_CYC 12'hfa0
`define OE_SETTLE 3'h7
`endif

// ---- verilog/modem_device.sv ----
// modem end of the host serial port: uart, pacing, straps, reporting, learn pin
`timescale 1ns/1ps
`include "modem_defines.svh"
module modem_device #(
  parameter int unsigned ELEM_CYC_HI = `ELEM_US_HI * `CYC_PER_US,
  parameter int unsigned ELEM_CYC_LO = `ELEM_US_LO * `CYC_PER_US,
  parameter int unsigned LEARN_WAIT_CYC = `LEARN_WAIT_MS * `CYC_PER_MS,
  parameter int unsigned LEARN_FLASH_CYC = `LEARN_FLASH_MS * `CYC_PER_MS,
  parameter int unsigned FLASH_HALF_CYC = `FLASH_HALF_MS * `CYC_PER_MS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  modem_if.dev link,
  input wire logic host_rate_strap,
  input wire logic radio_rate_strap,
  input wire logic mode_strap,
  output logic addressed_mode,
  output logic elem_tick,
  output modem_pkg::byte_t radio_tx_data,
  output logic radio_tx_valid,
  input wire logic radio_tx_ready,
  input wire logic radio_frame_sent,
  input wire logic radio_ack,
  input wire logic radio_no_ack,
  output logic radio_retry,
  input wire modem_pkg::byte_t radio_rx_data,
  input wire logic radio_rx_valid,
  output logic radio_rx_ready,
  output logic learn_start,
  input wire logic learn_done
);
  import modem_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic rxd_s, rts_n_s, rate_s, radio_s, mode_s;
  logic learn_s;
  logic learn_s_d_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
    end else begin
      sync1_reg <= {link.learn_indicator_pin, mode_strap, radio_rate_strap,
                    host_rate_strap, link.host_serial_in};
      sync2_reg <= sync1_reg;
    end
  end
  assign {learn_s, mode_s, radio_s, rate_s, rxd_s} = sync2_reg;
  assign rts_n_s = link.req_to_send_n;

  // the request line is a pin too
  logic rts1_reg, rts2_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rts1_reg <= 1'b1;
      rts2_reg <= 1'b1;
    end else begin
      rts1_reg <= rts_n_s;
      rts2_reg <= rts1_reg;
    end
  end

  // ==========================================
  // mode strap, caught once after release of reset
  logic mode_taken_reg, mode_reg;
  logic [1:0] settle_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= 2'h0;
      mode_taken_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else if (!mode_taken_reg) begin
      // wait for the synchroniser to fill before trusting the strap
      settle_reg <= settle_reg + 1'b1;
      if (&settle_reg) begin
        mode_taken_reg <= 1'b1;
        mode_reg <= mode_s;
      end
    end
  end
  assign addressed_mode = mode_reg;

  logic [12:0] bit_cyc;
  assign bit_cyc = rate_s ? `BIT_CYC_HI : `BIT_CYC_LO;

  // ==========================================
  // radio element timer
  logic [15:0] elem_cnt_reg;
  logic elem_tick_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      elem_cnt_reg <= '0;
      elem_tick_reg <= 1'b0;
    end else begin
      elem_tick_reg <= (elem_cnt_reg == '0);
      if (elem_cnt_reg == '0) begin
        elem_cnt_reg <= radio_s ? 16'(ELEM_CYC_HI - 1) : 16'(ELEM_CYC_LO - 1);
      end else begin
        elem_cnt_reg <= elem_cnt_reg - 1'b1;
      end
    end
  end
  assign elem_tick = elem_tick_reg;

  // ==========================================
  // host receiver into the buffer
  logic rx_busy_reg, rx_push_reg;
  logic [12:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  byte_t rx_sh_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_busy_reg <= 1'b0;
      rx_push_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
    end else begin
      rx_push_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rxd_s) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= bit_cyc >> 1;
          rx_bit_reg <= '0;
        end
      end else if (rx_cnt_reg == '0) begin
        rx_cnt_reg <= bit_cyc - 1'b1;
        rx_bit_reg <= rx_bit_reg + 1'b1;
        if (rx_bit_reg == '0 && rxd_s) begin
          rx_busy_reg <= 1'b0; // glitch, not a start bit
        end else if (rx_bit_reg == `UART_STOP_BIT) begin
          rx_busy_reg <= 1'b0;
          rx_push_reg <= rxd_s;
        end else if (rx_bit_reg != '0) begin
          rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end
    end
  end

  logic [4:0] fifo_level;
  modem_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) tx_buf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(rx_push_reg),
    .in_ready(),
    .in_data(rx_sh_reg),
    .out_valid(radio_tx_valid),
    .out_ready(radio_tx_ready),
    .out_data(radio_tx_data),
    .level(fifo_level)
  );

  // ==========================================
  // clear-to-send: margin covers a character already in flight
  logic cts_n_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_n_reg <= 1'b1;
    end else begin
      cts_n_reg <= (fifo_level >= 5'(`FIFO_DEPTH) - `CTS_MARGIN);
    end
  end
  assign link.clr_to_send_n = cts_n_reg;

  // ==========================================
  // addressed transfer outcome
  xfer_state_t xf_reg;
  logic [2:0] retry_reg;
  logic retry_pulse_reg;
  byte_t report_reg;
  logic tx_busy_reg;
  logic load_report;
  assign load_report = (xf_reg == XF_REPORT) && !tx_busy_reg && !rts2_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xf_reg <= XF_IDLE;
      retry_reg <= '0;
      retry_pulse_reg <= 1'b0;
      report_reg <= `CHAR_CONFIRM;
    end else begin
      retry_pulse_reg <= 1'b0;
      unique case (xf_reg)
        XF_IDLE: begin
          if (mode_reg && radio_frame_sent) begin
            xf_reg <= XF_WAIT;
            retry_reg <= '0;
          end
        end
        XF_WAIT: begin
          if (radio_ack) begin
            xf_reg <= XF_REPORT;
            report_reg <= `CHAR_CONFIRM;
          end else if (radio_no_ack) begin
            if (retry_reg == `RETRY_MAX) begin
              xf_reg <= XF_REPORT;
              report_reg <= `CHAR_FAIL;
            end else begin
              retry_reg <= retry_reg + 1'b1;
              retry_pulse_reg <= 1'b1;
            end
          end
        end
        XF_REPORT: begin
          if (load_report) xf_reg <= XF_IDLE;
        end
        default: xf_reg <= XF_IDLE;
      endcase
    end
  end
  assign radio_retry = retry_pulse_reg;

  // ==========================================
  // host transmitter; report character has priority over radio data
  logic [12:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_sh_reg;
  assign radio_rx_ready = !tx_busy_reg && !rts2_reg && (xf_reg != XF_REPORT);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= `UART_IDLE_FRAME;
    end else if (!tx_busy_reg) begin
      if (load_report || (radio_rx_valid && radio_rx_ready)) begin
        tx_busy_reg <= 1'b1;
        tx_cnt_reg <= bit_cyc - 1'b1;
        tx_bit_reg <= '0;
        tx_sh_reg <= {1'b1, load_report ? report_reg : radio_rx_data, 1'b0};
      end
    end else if (tx_cnt_reg == '0) begin
      tx_cnt_reg <= bit_cyc - 1'b1;
      tx_bit_reg <= tx_bit_reg + 1'b1;
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      if (tx_bit_reg == `UART_STOP_BIT) tx_busy_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end
  assign link.host_serial_out = tx_sh_reg[0];

  // ==========================================
  // learn pin: press sensing and indicator drive
  learn_state_t lrn_reg;
  logic [31:0] lrn_cnt_reg;
  logic [31:0] flash_cnt_reg;
  logic flash_on_reg;
  logic [2:0] oe_hist_reg;
  logic learn_pulse_reg;
  logic drive_oe;
  logic press;
  // own drive reads back as low, so ignore the pin until it has settled
  assign press = !learn_s && learn_s_d_reg && (oe_hist_reg == '0) && !drive_oe;
  assign drive_oe = (lrn_reg == LRN_WAIT) || ((lrn_reg == LRN_FLASH) && flash_on_reg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      learn_s_d_reg <= 1'b1;
      oe_hist_reg <= `OE_SETTLE;
    end else begin
      learn_s_d_reg <= learn_s;
      oe_hist_reg <= {oe_hist_reg[1:0], drive_oe};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lrn_reg <= LRN_OFF;
      lrn_cnt_reg <= '0;
      flash_cnt_reg <= '0;
      flash_on_reg <= 1'b0;
      learn_pulse_reg <= 1'b0;
    end else begin
      learn_pulse_reg <= 1'b0;
      unique case (lrn_reg)
        LRN_OFF: begin
          if (mode_reg && press) begin
            lrn_reg <= LRN_WAIT;
            lrn_cnt_reg <= LEARN_WAIT_CYC - 1;
            learn_pulse_reg <= 1'b1;
          end
        end
        LRN_WAIT: begin
          if (learn_done) begin
            lrn_reg <= LRN_FLASH;
            lrn_cnt_reg <= LEARN_FLASH_CYC - 1;
            flash_cnt_reg <= FLASH_HALF_CYC - 1;
            flash_on_reg <= 1'b1;
          end else if (lrn_cnt_reg == '0) begin
            lrn_reg <= LRN_OFF;
          end else begin
            lrn_cnt_reg <= lrn_cnt_reg - 1'b1;
          end
        end
        LRN_FLASH: begin
          if (lrn_cnt_reg == '0) begin
            lrn_reg <= LRN_OFF;
          end else begin
            lrn_cnt_reg <= lrn_cnt_reg - 1'b1;
          end
          if (flash_cnt_reg == '0) begin
            flash_cnt_reg <= FLASH_HALF_CYC - 1;
            flash_on_reg <= !flash_on_reg;
          end else begin
            flash_cnt_reg <= flash_cnt_reg - 1'b1;
          end
        end
        default: lrn_reg <= LRN_OFF;
      endcase
    end
  end
  assign learn_start = learn_pulse_reg;
  assign link.learn_dev_out = 1'b0;
  assign link.learn_dev_oe = drive_oe;
endmodule : modem_device

// ---- verilog/modem_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module modem_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic do_wr;
  logic do_rd;

  assign level = wr_ptr_reg - rd_ptr_reg;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : modem_fifo

// ---- verilog/modem_host.sv ----
// host end of the modem serial port: paced uart and learn pin control
`timescale 1ns/1ps
`include "modem_defines.svh"
module modem_host (
  input wire logic sys_clk,
  input wire logic rst_b,
  modem_if.host link,
  input wire logic rate_sel,
  input wire modem_pkg::byte_t tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output modem_pkg::byte_t rx_data,
  output logic rx_valid,
  input wire logic rx_enable,
  input wire logic learn_press,
  output logic indicator_lit
);
  import modem_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic rxd_s, cts_n_s, ind_s;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {link.learn_indicator_pin, link.clr_to_send_n, link.host_serial_out};
      sync2_reg <= sync1_reg;
    end
  end
  assign {ind_s, cts_n_s, rxd_s} = sync2_reg;

  logic [12:0] bit_cyc;
  assign bit_cyc = rate_sel ? `BIT_CYC_HI : `BIT_CYC_LO;

  logic rts_n_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rts_n_reg <= 1'b1;
    else rts_n_reg <= !rx_enable;
  end
  assign link.req_to_send_n = rts_n_reg;

  // ==========================================
  // transmitter, started only while clear-to-send is low
  logic tx_busy_reg;
  logic [12:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_sh_reg;
  assign tx_ready = !tx_busy_reg && !cts_n_s;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= `UART_IDLE_FRAME;
    end else if (!tx_busy_reg) begin
      if (tx_valid && tx_ready) begin
        tx_busy_reg <= 1'b1;
        tx_cnt_reg <= bit_cyc - 1'b1;
        tx_bit_reg <= '0;
        tx_sh_reg <= {1'b1, tx_data, 1'b0};
      end
    end else if (tx_cnt_reg == '0) begin
      tx_cnt_reg <= bit_cyc - 1'b1;
      tx_bit_reg <= tx_bit_reg + 1'b1;
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      if (tx_bit_reg == `UART_STOP_BIT) tx_busy_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end
  assign link.host_serial_in = tx_sh_reg[0];

  // ==========================================
  // receiver
  logic rx_busy_reg, rx_valid_reg;
  logic [12:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  byte_t rx_sh_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_busy_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rxd_s) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= bit_cyc >> 1;
          rx_bit_reg <= '0;
        end
      end else if (rx_cnt_reg == '0) begin
        rx_cnt_reg <= bit_cyc - 1'b1;
        rx_bit_reg <= rx_bit_reg + 1'b1;
        if (rx_bit_reg == '0 && rxd_s) begin
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == `UART_STOP_BIT) begin
          rx_busy_reg <= 1'b0;
          rx_valid_reg <= rxd_s;
        end else if (rx_bit_reg != '0) begin
          rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end
    end
  end
  assign rx_data = rx_sh_reg;
  assign rx_valid = rx_valid_reg;

  // ==========================================
  // learn pin: a brief press, then watch the indicator
  logic [11:0] press_cnt_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) press_cnt_reg <= '0;
    else if (learn_press && press_cnt_reg == '0) press_cnt_reg <= `PRESS_CYC;
    else if (press_cnt_reg != '0) press_cnt_reg <= press_cnt_reg - 1'b1;
  end
  assign link.learn_host_out = 1'b0;
  assign link.learn_host_oe = (press_cnt_reg != '0);

  logic lit_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) lit_reg <= 1'b0;
    else lit_reg <= !ind_s && (press_cnt_reg == '0);
  end
  assign indicator_lit = lit_reg;
endmodule : modem_host

// ---- verilog/modem_if.sv ----
// host serial connector between the modem and its host
`timescale 1ns/1ps
interface modem_if;
  logic host_serial_in;
  logic host_serial_out;
  logic clr_to_send_n;
  logic req_to_send_n;
  logic learn_dev_out;
  logic learn_dev_oe;
  logic learn_host_out;
  logic learn_host_oe;
  logic learn_indicator_pin;
  // open drain with pull-up: low when either side drives low
  assign learn_indicator_pin = ~((learn_dev_oe & ~learn_dev_out) |
                                 (learn_host_oe & ~learn_host_out));
  modport dev (input host_serial_in, output host_serial_out, output clr_to_send_n,
               input req_to_send_n, output learn_dev_out, output learn_dev_oe,
               input learn_indicator_pin);
  modport host (output host_serial_in, input host_serial_out, input clr_to_send_n,
                output req_to_send_n, output learn_host_out, output learn_host_oe,
                input learn_indicator_pin);
endinterface : modem_if

// ---- verilog/modem_pkg.sv ----
// types shared by both ends of the radio modem host port
package modem_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_WAIT = 2'b01,
    XF_REPORT = 2'b11
  } xfer_state_t;
  typedef enum logic [1:0] {
    LRN_OFF = 2'b00,
    LRN_WAIT = 2'b01,
    LRN_FLASH = 2'b11
  } learn_state_t;
endpackage : modem_pkg
